/* File: src/piw_pkg.sv */
package piw_pkg;

  // Field positions inside the first initialization word.
  localparam int unsigned FIRST_MODE_NEEDED_BIT = 0;
  localparam int unsigned FIRST_STANDALONE_BIT = 1;
  localparam int unsigned FIRST_ADDR_INTERVAL_BIT = 2;
  localparam int unsigned FIRST_LEVEL_TRIG_BIT = 3;
  localparam int unsigned FIRST_MARKER_BIT = 4;
  localparam int unsigned FIRST_VEC_LOW_LSB = 5;

  // Field positions inside the vector-base word.
  localparam int unsigned VEC_TYPE_LSB = 3;

  // Field positions inside the cascade-configuration word.
  localparam int unsigned CASC_ID_LSB = 0;

  // Field positions inside the operating mode word.
  localparam int unsigned MODE_CPU_SEQ_BIT = 0;
  localparam int unsigned MODE_AUTO_EOI_BIT = 1;
  localparam int unsigned MODE_SLAVE_BIT = 2;
  localparam int unsigned MODE_BUFFERED_BIT = 3;
  localparam int unsigned MODE_NESTED_BIT = 4;

  // Values after reset.
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam logic [7:0] MODE_DEFAULT = 8'h00;

  // Sequencer stages, one-hot.
  typedef enum logic [4:0] {
    PIW_IDLE = 5'h01,
    PIW_VEC = 5'h02,
    PIW_CASC = 5'h04,
    PIW_MODE = 5'h08,
    PIW_READY = 5'h10
  } piw_stage_t;

  // Host write port of the controller.
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic word_select_line;
    logic [7:0] din;
  } piw_bus_t;

  // Decoded configuration handed to the rest of the controller.
  typedef struct packed {
    logic init_done;
    logic level_trigger;
    logic addr_interval_four;
    logic [2:0] vector_low_bits;
    logic [7:0] vector_addr_bit;
    logic [4:0] vector_type_bit;
    logic standalone;
    logic is_master;
    logic [7:0] cascade_line_flag;
    logic [2:0] slave_number_bit;
    logic cpu_sequence_select;
    logic auto_end_of_irq;
    logic buffered;
    logic special_nested_priority;
  } piw_cfg_t;

endpackage

/* File: src/piw_wr_edge.sv */
`timescale 1ns/1ps
module piw_wr_edge
  import piw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic wr_n,
  output logic wr_active,
  output logic wr_fall,
  output logic wr_rise
);

  logic act_q;

  // A write is live only while both chip select and write strobe are low.
  assign wr_active = ~cs_n & ~wr_n;

  // Remember last cycle's strobe so its edges can be seen as single pulses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_q <= 1'b0;
    end else begin
      act_q <= wr_active;
    end
  end

  // Edge pulses are combinational; they stand for exactly one clock.
  assign wr_fall = wr_active & ~act_q;
  assign wr_rise = ~wr_active & act_q;

endmodule

/* File: src/piw_sequencer.sv */
`timescale 1ns/1ps
module piw_sequencer
  import piw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire piw_bus_t bus,
  input wire logic master_strap,
  output logic init_done,
  output logic [7:0] init_word_first,
  output logic [7:0] vector_base_word,
  output logic [7:0] cascade_config_word,
  output logic [7:0] operating_mode_word,
  output piw_cfg_t cfg
);

  logic wr_active;
  logic wr_fall;
  logic wr_rise;
  piw_stage_t stage_q;
  piw_stage_t stage_d;
  piw_stage_t next_stage;
  piw_stage_t target;
  logic loaded_q;
  logic loaded_d;
  logic first_write;
  logic load_en;
  logic in_seq;
  logic [7:0] first_q;
  logic [7:0] vec_q;
  logic [7:0] casc_q;
  logic [7:0] mode_q;
  logic master_now;

  // Strobe edges come from one small detector shared by all stages.
  piw_wr_edge u_edge (
    .clk(clk),
    .nrst(nrst),
    .cs_n(bus.cs_n),
    .wr_n(bus.wr_n),
    .wr_active(wr_active),
    .wr_fall(wr_fall),
    .wr_rise(wr_rise)
  );

  // The opening word is recognised in any stage, so software can always recover.
  assign first_write = wr_active & ~bus.word_select_line
                     & bus.din[FIRST_MARKER_BIT];
  assign in_seq = (stage_q == PIW_VEC) | (stage_q == PIW_CASC) | (stage_q == PIW_MODE);
  // Between the first word and ready, every select-high write belongs to the sequence.
  assign load_en = wr_active & bus.word_select_line & in_seq;

  // Which stage follows the current one, skipping optional words.
  always_comb begin
    next_stage = PIW_READY;
    case (stage_q)
      PIW_VEC: begin
        if (!first_q[FIRST_STANDALONE_BIT]) begin
          next_stage = PIW_CASC;
        end else if (first_q[FIRST_MODE_NEEDED_BIT]) begin
          next_stage = PIW_MODE;
        end else begin
          next_stage = PIW_READY;
        end
      end
      PIW_CASC: begin
        if (first_q[FIRST_MODE_NEEDED_BIT]) begin
          next_stage = PIW_MODE;
        end else begin
          next_stage = PIW_READY;
        end
      end
      default: begin
        next_stage = PIW_READY;
      end
    endcase
  end

  // A loaded word is released on the following strobe fall, and that same
  // write then lands in the next stage.
  always_comb begin
    target = stage_q;
    if (wr_fall && loaded_q && in_seq) begin
      target = next_stage;
    end
  end

  // Stage and loaded flag advance together.
  always_comb begin
    stage_d = stage_q;
    loaded_d = loaded_q;
    if (first_write) begin
      stage_d = PIW_VEC;
      loaded_d = 1'b0;
    end else if (in_seq) begin
      if (target != stage_q) begin
        stage_d = target;
        loaded_d = 1'b0;
      end
      if (target != PIW_READY && load_en) begin
        loaded_d = 1'b1;
      end
      // With no further word expected, the sequence ends as the last write ends.
      if (wr_rise && loaded_q && next_stage == PIW_READY) begin
        stage_d = PIW_READY;
      end
    end
  end

  // Stage register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_q <= PIW_IDLE;
      loaded_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      loaded_q <= loaded_d;
    end
  end

  // First word; it is taken on every active cycle of its write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_q <= WORD_RST;
    end else if (first_write) begin
      first_q <= bus.din;
    end
  end

  // Vector-base word, sampled on the rising clock while the write stands.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vec_q <= WORD_RST;
    end else if (!first_write && load_en && target == PIW_VEC) begin
      vec_q <= bus.din;
    end
  end

  // Cascade-configuration word; the host is trusted to send it when cascaded.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      casc_q <= WORD_RST;
    end else if (!first_write && load_en && target == PIW_CASC) begin
      casc_q <= bus.din;
    end
  end

  // Mode word; a first word without the mode flag forces the defaults so a
  // stale mode from an earlier sequence cannot survive.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= MODE_DEFAULT;
    end else if (first_write && !bus.din[FIRST_MODE_NEEDED_BIT]) begin
      mode_q <= MODE_DEFAULT;
    end else if (!first_write && load_en && target == PIW_MODE) begin
      mode_q <= bus.din;
    end
  end

  // Outside buffered mode the role comes from the strap, not the mode word.
  assign master_now = mode_q[MODE_BUFFERED_BIT] ? ~mode_q[MODE_SLAVE_BIT]
                                                : master_strap;

  // Decoded configuration is registered so every consumer sees a clean level.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= '0;
    end else begin
      cfg.init_done <= (stage_q == PIW_READY);
      cfg.level_trigger <= first_q[FIRST_LEVEL_TRIG_BIT];
      cfg.addr_interval_four <= first_q[FIRST_ADDR_INTERVAL_BIT];
      cfg.vector_low_bits <= first_q[7:FIRST_VEC_LOW_LSB];
      // High address byte only has meaning in the single-byte sequence.
      cfg.vector_addr_bit <= mode_q[MODE_CPU_SEQ_BIT] ? vec_q : WORD_RST;
      cfg.vector_type_bit <= vec_q[7:VEC_TYPE_LSB];
      cfg.standalone <= first_q[FIRST_STANDALONE_BIT];
      cfg.is_master <= master_now;
      // Slave inputs are marked only for a cascaded master.
      cfg.cascade_line_flag <= (!first_q[FIRST_STANDALONE_BIT] && master_now)
                               ? casc_q : WORD_RST;
      // Upper cascade bits are ignored as a slave; the host should send zeros.
      cfg.slave_number_bit <= casc_q[CASC_ID_LSB +: 3];
      cfg.cpu_sequence_select <= mode_q[MODE_CPU_SEQ_BIT];
      cfg.auto_end_of_irq <= mode_q[MODE_AUTO_EOI_BIT];
      cfg.buffered <= mode_q[MODE_BUFFERED_BIT];
      // Bits five to seven are unused and left undecoded.
      cfg.special_nested_priority <= mode_q[MODE_NESTED_BIT];
    end
  end

  // Raw words come straight from flip-flops; the ready level is decoded from the stage register.
  assign init_done = (stage_q == PIW_READY);
  assign init_word_first = first_q;
  assign vector_base_word = vec_q;
  assign cascade_config_word = casc_q;
  assign operating_mode_word = mode_q;

endmodule

/* File: tb/piw_seq_asserts.sv */
`timescale 1ns/1ps
module piw_seq_asserts
  import piw_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire piw_bus_t bus,
  input wire logic master_strap,
  input wire logic init_done,
  input wire logic [7:0] init_word_first,
  input wire logic [7:0] vector_base_word,
  input wire logic [7:0] cascade_config_word,
  input wire logic [7:0] operating_mode_word,
  input wire piw_cfg_t cfg
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // A live select-low write with the marker bit set opens a sequence.
  logic first_wr;
  assign first_wr = !bus.cs_n && !bus.wr_n && !bus.word_select_line && bus.din[4];
  first_word_a: assert property (first_wr |=>
    init_word_first == $past(bus.din) && !init_done) else $error("first word not taken");
  mode_default_a: assert property (first_wr && !bus.din[0] |=>
    operating_mode_word == 8'h00) else $error("mode word not cleared");
  standalone_a: assert property (cfg.standalone == $past(init_word_first[1]))
    else $error("standalone flag wrong");
  type_bits_a: assert property (cfg.vector_type_bit == $past(vector_base_word[7:3]))
    else $error("vector type bits wrong");
  addr_bits_a: assert property (cfg.vector_addr_bit ==
    ($past(operating_mode_word[0]) ? $past(vector_base_word) : 8'h00))
    else $error("addr bits wrong");
  slave_id_a: assert property (cfg.slave_number_bit == $past(cascade_config_word[2:0]))
    else $error("slave id wrong");
  // Each decoded mode flag sits at its own bit of the mode word.
  mode_bits_a: assert property ({cfg.cpu_sequence_select,
    cfg.auto_end_of_irq, cfg.buffered, cfg.special_nested_priority} ==
    $past({operating_mode_word[0], operating_mode_word[1], operating_mode_word[3],
    operating_mode_word[4]})) else $error("mode decode wrong");
  // The decode is held at zero during reset, so the first edge after release is skipped.
  master_role_a: assert property ($past(nrst) |-> cfg.is_master ==
    ($past(operating_mode_word[3]) ? !$past(operating_mode_word[2]) : $past(master_strap)))
    else $error("role wrong");
  // Main scenarios: a sequence opened, completed, and a buffered slave set up.
  cover property (first_wr);
  cover property ($rose(init_done));
  cover property (cfg.buffered && !cfg.is_master);
endmodule

/* File: tb/piw_host.sv */
`timescale 1ns/1ps
// Host side of the write port; one word per strobe, strobe high a cycle between words.
module piw_host
  import piw_pkg::*;
(
  input wire logic clk,
  output piw_bus_t bus
);
  // Idle bus from time zero.
  initial begin
    bus = '{cs_n: 1'b1, wr_n: 1'b1, word_select_line: 1'b0, din: 8'h00};
  end
  // Launched after an edge and held over the sampling edge; callers zero spare bits.
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #2;
    bus = '{cs_n: 1'b0, wr_n: 1'b0, word_select_line: sel, din: d};
    @(posedge clk);
    #2;
    // Undriven data is not pulled, so it shows the inverse instead of a stale value.
    bus = '{cs_n: 1'b1, wr_n: 1'b1, word_select_line: sel, din: ~d};
  endtask
endmodule

/* File: tb/piw_sequencer_tb_top.sv */
`timescale 1ns/1ps
module piw_sequencer_tb_top;
  import piw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic master_strap = 1'b1;
  logic init_done;
  logic [7:0] first_q, vec_q, casc_q, mode_q, mm;
  piw_bus_t bus;
  piw_cfg_t cfg;
  int mismatches = 0;
  int comparisons = 0;
  // A 40 MHz clock.
  always #12.5 clk = ~clk;
  piw_host i_host (.clk(clk), .bus(bus));
  piw_sequencer i_dut (.clk(clk), .nrst(nrst), .bus(bus), .master_strap(master_strap),
    .init_done(init_done), .init_word_first(first_q), .vector_base_word(vec_q),
    .cascade_config_word(casc_q), .operating_mode_word(mode_q), .cfg(cfg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Full sequence, then the decode; cfg trails the words by one edge.
  task automatic init(input logic [7:0] f, input logic [7:0] v, input logic [7:0] c,
      input logic [7:0] m);
    mm = f[0] ? m : 8'h00;
    i_host.wr(1'b0, f);
    i_host.wr(1'b1, v);
    repeat (2) @(posedge clk);
    #2;
    if (!f[1] || f[0]) chk({7'h0, init_done}, 8'h00);
    if (!f[1]) i_host.wr(1'b1, c);
    if (f[0]) i_host.wr(1'b1, m);
    repeat (3) @(posedge clk);
    #2;
    chk({7'h0, init_done}, 8'h01);
    chk(vec_q, v);
    chk(mode_q, mm);
    chk(first_q, f);
    chk({cfg.vector_low_bits, 2'h0, cfg.level_trigger, cfg.addr_interval_four, cfg.init_done},
      {f[7:5], 2'h0, f[3:2], 1'b1});
    chk({7'h0, cfg.standalone}, {7'h0, f[1]});
    chk({3'h0, cfg.vector_type_bit}, {3'h0, v[7:3]});
    chk(cfg.vector_addr_bit, mm[0] ? v : 8'h00);
    chk({4'h0, cfg.special_nested_priority, cfg.buffered, cfg.auto_end_of_irq,
      cfg.cpu_sequence_select}, {4'h0, mm[4:3], mm[1:0]});
    chk({7'h0, cfg.is_master}, {7'h0, mm[3] ? !mm[2] : master_strap});
    if (!f[1]) chk(casc_q, c);
    if (!f[1]) chk({5'h0, cfg.slave_number_bit}, {5'h0, c[2:0]});
    chk(cfg.cascade_line_flag, (!f[1] && (mm[3] ? !mm[2] : master_strap)) ? c : 8'h00);
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge clk);
    #2;
    nrst = 1'b1;
    init(8'h12, 8'h40, 8'h00, 8'h00);
    i_host.wr(1'b1, 8'hff);
    i_host.wr(1'b0, 8'h08);
    @(posedge clk);
    #2;
    chk(vec_q, 8'h40);
    chk(first_q, 8'h12);
    chk({7'h0, init_done}, 8'h01);
    i_host.wr(1'b0, 8'h19);
    chk({7'h0, init_done}, 8'h00);
    i_host.wr(1'b1, 8'haa);
    chk(vec_q, 8'haa);
    init(8'h11, 8'hb5, 8'h04, 8'h0d);
    init(8'h19, 8'h28, 8'h84, 8'h12);
    master_strap = 1'b0;
    init(8'hf4, 8'h9f, 8'h03, 8'h00);
    wrap_up();
  end
  // The tests take about 70 cycles; a hang is cut off well beyond that.
  initial begin
    #50000;
    mismatches++;
    wrap_up();
  end
endmodule
bind piw_sequencer piw_seq_asserts i_chk (.clk(clk), .nrst(nrst), .bus(bus),
  .master_strap(master_strap), .init_done(init_done), .init_word_first(init_word_first),
  .vector_base_word(vector_base_word), .cascade_config_word(cascade_config_word),
  .operating_mode_word(operating_mode_word), .cfg(cfg));
